// file: common/mitb_pkg.sv
/*
 * Package for the interrupt and time base block: register indices,
 * field positions, reset values, vector codes and carrier structs.
 * Assumes one system clock and an 8-bit register port.
 */
package mitb_pkg;
	localparam logic [2:0] REG_INTC0 = 3'h0;
	localparam logic [2:0] REG_INTC1 = 3'h1;
	localparam logic [2:0] REG_MFI0 = 3'h2;
	localparam logic [2:0] REG_MFI1 = 3'h3;
	localparam logic [2:0] REG_TBASE = 3'h4;
	// Register index 0 fields
	localparam int INTC0_GIE = 0;
	localparam int INTC0_GRP0E = 1;
	localparam int INTC0_GRP1E = 2;
	localparam int INTC0_GRP0F = 4;
	localparam int INTC0_GRP1F = 5;
	// Register index 1 fields
	localparam int INTC1_CONVE = 1;
	localparam int INTC1_TICKE = 2;
	localparam int INTC1_LOWE = 3;
	localparam int INTC1_CONVF = 5;
	localparam int INTC1_TICKF = 6;
	localparam int INTC1_LOWF = 7;
	// Timer fields: enables at 0..2, flags at 4..6 (P, A, B)
	localparam int MFI_EN_POS = 0;
	localparam int MFI_FLAG_POS = 4;
	// Time base control fields
	localparam int TBASE_RUN = 7;
	localparam int TBASE_CLKSEL = 6;
	localparam int TBASE_PER_LSB = 4;
	localparam logic [7:0] TBASE_RESET = 8'h30;
	localparam logic [1:0] SYS_DIV_LAST = 2'h3;
	localparam int TICK_BASE_CYCLES = 4096;
	// Source flag indices
	localparam int SRC_N = 6;
	localparam int S_T0P = 0;
	localparam int S_T0A = 1;
	localparam int S_T1P = 2;
	localparam int S_T1A = 3;
	localparam int S_T1B = 4;
	localparam int S_LOW = 5;
	localparam logic [SRC_N-1:0] GROUP0_MASK = 6'h03;
	localparam logic [SRC_N-1:0] GROUP1_MASK = 6'h3C;

	typedef enum logic [1:0] {
		VEC_MF0 = 2'b00,
		VEC_CONV = 2'b01,
		VEC_TICK = 2'b10,
		VEC_MF1 = 2'b11
	} mitb_vec_type;

	typedef struct packed {
		logic conv_done;
		logic low_supply;
		logic tm1_b;
		logic tm1_a;
		logic tm1_p;
		logic tm0_a;
		logic tm0_p;
	} mitb_evt_type;

	typedef struct packed {
		logic take;
		mitb_vec_type vector;
	} mitb_irq_type;
endpackage : mitb_pkg

// file: core/mitb_core.sv
/*
 * Interrupt request logic with combined groups, converter-done and
 * time base tick sources, sleep wake-up and return handling.
 * Assumes the CPU pushes the PC and jumps on irq.take, reports
 * return instructions as one-cycle pulses, and that event inputs
 * are synchronous to clock; the slow oscillator level passes a two-flop synchroniser.
 */
// The address-and-strobe port and the address map were decided locally.
// Function
// - A combined flag sets whenever any grouped source flag becomes set.
// - Enabled combined group with a grouped request calls its vector if stack free.
// - Taking a combined vector clears its combined flag and the global enable.
// - Taking a combined vector leaves grouped source flags set for software.
// - The converter-done flag sets when a conversion completes.
// - Converter vector needs global enable, converter enable and a free stack.
// - Taking the converter vector clears its flag and the global enable.
// - The tick flag sets on every time base divider overflow.
// - Tick vector needs global and tick enables; taking it clears its flag and the global enable.
// - Time base runs only while control bit 7 is 1; it resets to 0.
// - Tick clock is slow oscillator when select is 0, system clock / 4 when 1.
// - Period codes 00..11 give 4096, 8192, 16384, 32768 tick clocks; reset 11.
// - Low-supply flag sets on detection; vector needs global, own and group enables.
// - Taking low-supply clears only global enable and group flag, not its flag.
// - Timer modules give P and A match flags and enables, enhanced adds B.
// - Timer vector needs three enables; taking it leaves match flags for software.
// - In sleep any request flag rising from 0 to 1 wakes the device.
// - A flag already set before sleep produces no wake-up.
// - A set flag stays set while disabled until serviced or cleared by software.
// - Entry pushes only the PC; software saves other registers.
// - Return-from-interrupt sets the global enable; plain return leaves it.
// - With the stack full no request is taken until it frees up.
// - With global enable 0 no vector is taken, flags still record.
`timescale 1ns/1ps
module mitb_core
	import mitb_pkg::*;
#(
	parameter int TICK_BASE = TICK_BASE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire mitb_evt_type evt,
	input wire logic tick_slow_clock,
	input wire logic stack_full,
	input wire logic sleeping,
	input wire logic ret_evt,
	input wire logic return_from_interrupt,
	output mitb_irq_type irq,
	output logic wake
);
	logic global_irq_enable;
	logic [1:0] combined_irq_enable;
	logic [1:0] combined_request_flags;
	logic conv_done_flag;
	logic conv_done_irq_enable;
	logic tick_request_flag;
	logic tick_irq_enable;
	logic [SRC_N-1:0] src_flag;
	logic [SRC_N-1:0] src_prev;
	logic [SRC_N-1:0] src_en;
	logic [SRC_N-1:0] src_evt;
	logic [SRC_N-1:0] src_wr_hit;
	logic [SRC_N-1:0] src_wr_flag;
	logic [SRC_N-1:0] src_wr_en;
	logic tick_run;
	logic tick_clock_select;
	logic [1:0] tick_period_select;
	logic [1:0] sys_div;
	logic [2:0] slow_sync;
	logic [15:0] tb_count;
	logic [15:0] tb_last;
	logic tick_clock;
	logic tb_ovf;
	logic [9:0] all_flags;
	logic [9:0] all_prev;
	logic mf0_req;
	logic mf1_req;
	logic conv_req;
	logic tick_req;
	logic take_now;
	mitb_vec_type next_vector;
	logic wr0;
	logic wr1;

	assign wr0 = reg_wr && reg_addr == REG_INTC0;
	assign wr1 = reg_wr && reg_addr == REG_INTC1;

	// Source events in flag order
	assign src_evt = {evt.low_supply, evt.tm1_b, evt.tm1_a, evt.tm1_p, evt.tm0_a, evt.tm0_p};

	// Write decode for the timer and low-supply bits
	always_comb begin
		src_wr_hit = '0;
		src_wr_flag = '0;
		src_wr_en = '0;
		if (reg_wr && reg_addr == REG_MFI0) begin
			src_wr_hit[1:0] = 2'h3;
			src_wr_flag[1:0] = reg_wdata[MFI_FLAG_POS +: 2];
			src_wr_en[1:0] = reg_wdata[MFI_EN_POS +: 2];
		end else if (reg_wr && reg_addr == REG_MFI1) begin
			src_wr_hit[4:2] = 3'h7;
			src_wr_flag[4:2] = reg_wdata[MFI_FLAG_POS +: 3];
			src_wr_en[4:2] = reg_wdata[MFI_EN_POS +: 3];
		end else if (wr1) begin
			src_wr_hit[S_LOW] = 1'b1;
			src_wr_flag[S_LOW] = reg_wdata[INTC1_LOWF];
			src_wr_en[S_LOW] = reg_wdata[INTC1_LOWE];
		end
	end

	// Source flags: hardware set wins over software clear
	genvar gi;
	generate
		for (gi = 0; gi < SRC_N; gi++) begin : g_src
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					src_flag[gi] <= 1'b0;
					src_en[gi] <= 1'b0;
				end else begin
					if (src_evt[gi]) begin
						src_flag[gi] <= 1'b1;
					end else if (src_wr_hit[gi]) begin
						src_flag[gi] <= src_wr_flag[gi];
					end
					if (src_wr_hit[gi]) begin
						src_en[gi] <= src_wr_en[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			src_prev <= '0;
		end else begin
			src_prev <= src_flag;
		end
	end

	// Request evaluation and fixed priority
	assign mf0_req = combined_request_flags[0] && combined_irq_enable[0] && |(src_flag & src_en & GROUP0_MASK);
	assign mf1_req = combined_request_flags[1] && combined_irq_enable[1] && |(src_flag & src_en & GROUP1_MASK);
	assign conv_req = conv_done_flag && conv_done_irq_enable;
	assign tick_req = tick_request_flag && tick_irq_enable;
	assign take_now = global_irq_enable && !stack_full && (mf0_req || conv_req || tick_req || mf1_req);

	always_comb begin
		if (mf0_req) begin
			next_vector = VEC_MF0;
		end else if (conv_req) begin
			next_vector = VEC_CONV;
		end else if (tick_req) begin
			next_vector = VEC_TICK;
		end else begin
			next_vector = VEC_MF1;
		end
	end

	// Vector call pulse; the CPU pushes the PC only
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			irq <= '{take: 1'b0, vector: VEC_MF0};
		end else begin
			irq.take <= take_now;
			if (take_now) begin
				irq.vector <= next_vector;
			end
		end
	end

	// Global enable
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			global_irq_enable <= 1'b0;
		end else if (take_now) begin
			global_irq_enable <= 1'b0;
		end else if (return_from_interrupt) begin
			global_irq_enable <= 1'b1;
		end else if (wr0) begin
			global_irq_enable <= reg_wdata[INTC0_GIE];
		end
	end

	// Combined flags and enables
	genvar gm;
	generate
		for (gm = 0; gm < 2; gm++) begin : g_mf
			logic rise;
			assign rise = |(src_flag & ~src_prev & (gm == 0 ? GROUP0_MASK : GROUP1_MASK));
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					combined_request_flags[gm] <= 1'b0;
					combined_irq_enable[gm] <= 1'b0;
				end else begin
					if (rise) begin
						combined_request_flags[gm] <= 1'b1;
					end else if (take_now && next_vector == (gm == 0 ? VEC_MF0 : VEC_MF1)) begin
						combined_request_flags[gm] <= 1'b0;
					end else if (wr0) begin
						combined_request_flags[gm] <= reg_wdata[INTC0_GRP0F + gm];
					end
					if (wr0) begin
						combined_irq_enable[gm] <= reg_wdata[INTC0_GRP0E + gm];
					end
				end
			end
		end
	endgenerate

	// Converter-done and tick flags
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			conv_done_flag <= 1'b0;
			tick_request_flag <= 1'b0;
			conv_done_irq_enable <= 1'b0;
			tick_irq_enable <= 1'b0;
		end else begin
			if (evt.conv_done) begin
				conv_done_flag <= 1'b1;
			end else if (take_now && next_vector == VEC_CONV) begin
				conv_done_flag <= 1'b0;
			end else if (wr1) begin
				conv_done_flag <= reg_wdata[INTC1_CONVF];
			end
			if (tb_ovf) begin
				tick_request_flag <= 1'b1;
			end else if (take_now && next_vector == VEC_TICK) begin
				tick_request_flag <= 1'b0;
			end else if (wr1) begin
				tick_request_flag <= reg_wdata[INTC1_TICKF];
			end
			if (wr1) begin
				conv_done_irq_enable <= reg_wdata[INTC1_CONVE];
				tick_irq_enable <= reg_wdata[INTC1_TICKE];
			end
		end
	end

	// Time base control register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tick_run <= TBASE_RESET[TBASE_RUN];
			tick_clock_select <= TBASE_RESET[TBASE_CLKSEL];
			tick_period_select <= TBASE_RESET[TBASE_PER_LSB +: 2];
		end else if (reg_wr && reg_addr == REG_TBASE) begin
			tick_run <= reg_wdata[TBASE_RUN];
			tick_clock_select <= reg_wdata[TBASE_CLKSEL];
			tick_period_select <= reg_wdata[TBASE_PER_LSB +: 2];
		end
	end

	// Tick clock source: slow oscillator edge or system clock / 4
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slow_sync <= '0;
			sys_div <= '0;
		end else begin
			slow_sync <= {slow_sync[1:0], tick_slow_clock};
			sys_div <= sys_div + 2'h1;
		end
	end

	assign tick_clock = tick_clock_select ? (sys_div == SYS_DIV_LAST) : (slow_sync[1] && !slow_sync[2]);
	assign tb_last = 16'((TICK_BASE << tick_period_select) - 1);
	assign tb_ovf = tick_run && tick_clock && tb_count == tb_last;

	// Time base divider
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tb_count <= '0;
		end else if (!tick_run) begin
			tb_count <= '0;
		end else if (tb_ovf) begin
			tb_count <= '0;
		end else if (tick_clock) begin
			tb_count <= tb_count + 16'h1;
		end
	end

	// Wake on any flag rising while asleep
	assign all_flags = {src_flag, combined_request_flags, conv_done_flag, tick_request_flag};

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			all_prev <= '0;
			wake <= 1'b0;
		end else begin
			all_prev <= all_flags;
			wake <= sleeping && |(all_flags & ~all_prev);
		end
	end

	// Read port, data valid one cycle after the strobe
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == REG_INTC0) begin
			reg_rdata <= {2'b00, combined_request_flags, 1'b0, combined_irq_enable, global_irq_enable};
		end else if (reg_addr == REG_INTC1) begin
			reg_rdata <= {src_flag[S_LOW], tick_request_flag, conv_done_flag, 1'b0,
				src_en[S_LOW], tick_irq_enable, conv_done_irq_enable, 1'b0};
		end else if (reg_addr == REG_MFI0) begin
			reg_rdata <= {2'b00, src_flag[S_T0A:S_T0P], 2'b00, src_en[S_T0A:S_T0P]};
		end else if (reg_addr == REG_MFI1) begin
			reg_rdata <= {1'b0, src_flag[S_T1B:S_T1P], 1'b0, src_en[S_T1B:S_T1P]};
		end else if (reg_addr == REG_TBASE) begin
			reg_rdata <= {tick_run, tick_clock_select, tick_period_select, 4'h0};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	chk_take_gated: assert property (irq.take |-> $past(global_irq_enable) && !$past(stack_full))
		else $error("vector taken without global enable or with full stack");
	chk_full_blocks: assert property (stack_full |=> !irq.take)
		else $error("vector taken while stack full");
	chk_take_gie: assert property (irq.take |-> !global_irq_enable)
		else $error("global enable not cleared on entry");
	chk_conv_clear: assert property (irq.take && irq.vector == VEC_CONV && !$past(evt.conv_done)
		|-> !conv_done_flag)
		else $error("converter flag not cleared on entry");
	chk_src_kept: assert property (irq.take && !$past(reg_wr) |-> (src_flag & $past(src_flag)) == $past(src_flag))
		else $error("source flag cleared by entry");
	chk_return_from_interrupt_sets: assert property (return_from_interrupt && !take_now |=> global_irq_enable)
		else $error("return from interrupt did not set global enable");
	chk_ret_keeps: assert property (ret_evt && !return_from_interrupt && !take_now && !wr0
		|=> global_irq_enable == $past(global_irq_enable))
		else $error("plain return changed global enable");
	chk_conv_set: assert property (evt.conv_done |=> conv_done_flag)
		else $error("converter flag not set");
	chk_wake_cause: assert property (wake |-> $past(sleeping) && $past(all_flags & ~all_prev) != '0)
		else $error("wake without a rising flag");
	chk_tick_off: assert property (!tick_run |=> !tb_ovf && tb_count == 16'h0)
		else $error("time base ran while off");
	chk_mf_priority: assert property (irq.take && irq.vector != VEC_MF0 |-> !$past(mf0_req))
		else $error("lower priority taken over group 0");
	chk_group_set: assert property ($rose(src_flag[S_LOW]) |=> combined_request_flags[1])
		else $error("combined flag not set by source");

	cov_conv_take: cover property (irq.take && irq.vector == VEC_CONV);
	cov_mf1_take: cover property (irq.take && irq.vector == VEC_MF1);
	cov_tick_ovf: cover property (tb_ovf);
	cov_wake: cover property (wake);
	cov_mf0_take: cover property (irq.take && irq.vector == VEC_MF0);

	chk_tick_set: assert property (tb_ovf |=> tick_request_flag)
		else $error("tick flag not set on overflow");
	chk_tick_clear: assert property (irq.take && irq.vector == VEC_TICK && !$past(tb_ovf)
		|-> !tick_request_flag)
		else $error("tick flag not cleared on entry");
	chk_tick_gated: assert property (irq.take && irq.vector == VEC_TICK |-> $past(tick_irq_enable))
		else $error("tick vector taken while disabled");
	chk_conv_gated: assert property (irq.take && irq.vector == VEC_CONV |-> $past(conv_done_irq_enable))
		else $error("converter vector taken while disabled");
	chk_grp1_gated: assert property (irq.take && irq.vector == VEC_MF1 |-> $past(combined_irq_enable[1]))
		else $error("group 1 vector taken while disabled");
	chk_grp0_set: assert property ($rose(src_flag[S_T0P]) |=> combined_request_flags[0])
		else $error("group 0 flag not set by source");
	chk_flag_held: assert property (conv_done_flag && !take_now && !wr1 |=> conv_done_flag)
		else $error("converter flag lost while pending");
endmodule : mitb_core

// file: tb/mitb_cpu_model.sv
/*
 * Behavioural CPU sequencer: pushes on each take, returns after a
 * short service time by either return kind.
 * Assumes irq is registered in the system clock domain.
 */
`timescale 1ns/1ps
module mitb_cpu_model
	import mitb_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire mitb_irq_type irq,
	input wire logic use_return_from_interrupt,
	input wire logic hold_full,
	output logic stack_full,
	output logic return_from_interrupt,
	output logic ret_evt
);
	int depth;
	int svc;

	assign stack_full = (depth >= DEPTH) | hold_full;

	// Only the return address is pushed; no calls while in service
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			depth <= 0;
			svc <= 0;
			return_from_interrupt <= 1'b0;
			ret_evt <= 1'b0;
		end else begin
			return_from_interrupt <= 1'b0;
			ret_evt <= 1'b0;
			if (irq.take) begin
				depth <= depth + 1;
				svc <= 4;
			end else if (svc != 0) begin
				svc <= svc - 1;
				if (svc == 1) begin
					depth <= depth - 1;
					return_from_interrupt <= use_return_from_interrupt;
					ret_evt <= !use_return_from_interrupt;
				end
			end
		end
	end
endmodule : mitb_cpu_model

// file: tb/mitb_core_tb_top.sv
/*
 * Testbench: register tasks, event pulses and scenario tasks.
 * Assumes a 50 MHz clock and a shortened time base count.
 */
`timescale 1ns/1ps
module mitb_core_tb_top;
	import mitb_pkg::*;
	localparam int TB = 4;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	mitb_evt_type evt = '0;
	logic [2:0] sc = 3'h0;
	logic tick_slow_clock;
	logic stack_full, sleeping = 1'b0, ret_evt, return_from_interrupt;
	logic use_return_from_interrupt = 1'b0, hold_full = 1'b0;
	mitb_irq_type irq;
	logic wake;
	int bad_count = 0, n_compared = 0, takes, wakes, n;

	always #10 clock = ~clock;
	always @(posedge clock) sc <= sc + 3'h1;
	assign tick_slow_clock = sc[2];

	mitb_core #(.TICK_BASE(TB)) dut_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt),
		.tick_slow_clock(tick_slow_clock), .stack_full(stack_full), .sleeping(sleeping),
		.ret_evt(ret_evt), .return_from_interrupt(return_from_interrupt), .irq(irq), .wake(wake));
	mitb_cpu_model cpu_u (.clock(clock), .rst_b(rst_b), .irq(irq), .use_return_from_interrupt(use_return_from_interrupt),
		.hold_full(hold_full), .stack_full(stack_full), .return_from_interrupt(return_from_interrupt),
		.ret_evt(ret_evt));

	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock) begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
		end
		@(posedge clock) reg_wr <= 1'b0;
	endtask : wr

	task rd_check(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clock) begin
			reg_addr <= a;
			reg_rd <= 1'b1;
		end
		@(posedge clock) reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask : rd_check

	task pulse(input logic [6:0] v);
		@(posedge clock) evt <= mitb_evt_type'(v);
		@(posedge clock) evt <= '0;
	endtask : pulse

	task quiet(input int cycles);
		takes = 0;
		wakes = 0;
		repeat (cycles) begin
			@(posedge clock);
			#1;
			if (irq.take === 1'b1) takes++;
			if (wake === 1'b1) wakes++;
		end
	endtask : quiet

	task expect_take(input logic [1:0] v);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
			if (n > 300) begin
				bad_count++;
				$display("wrong value at %0t: seen %h expected %h", $time, 8'h00, 8'h01);
				report_and_stop;
			end
		end while (irq.take !== 1'b1);
		check({6'h00, irq.vector}, {6'h00, v});
	endtask : expect_take

	task reset_values;
		rd_check(REG_INTC0, 8'h00);
		rd_check(REG_TBASE, 8'h30);
		wr(3'h5, 8'hFF);
		rd_check(3'h5, 8'h00);
	endtask : reset_values

	task conv_done_entry;
		wr(REG_INTC1, 8'h02);
		wr(REG_INTC0, 8'h01);
		pulse(7'h40);
		expect_take(VEC_CONV);
		rd_check(REG_INTC1, 8'h02);
		quiet(6);
		rd_check(REG_INTC0, 8'h00);
	endtask : conv_done_entry

	task group_entries;
		wr(REG_MFI0, 8'h01);
		wr(REG_INTC0, 8'h03);
		pulse(7'h01);
		expect_take(VEC_MF0);
		rd_check(REG_INTC0, 8'h02);
		rd_check(REG_MFI0, 8'h11);
		wr(REG_MFI0, 8'h01);
		wr(REG_INTC1, 8'h08);
		wr(REG_INTC0, 8'h05);
		pulse(7'h20);
		expect_take(VEC_MF1);
		rd_check(REG_INTC1, 8'h88);
		rd_check(REG_INTC0, 8'h04);
		wr(REG_INTC1, 8'h00);
	endtask : group_entries

	task blocked_entry;
		wr(REG_INTC1, 8'h02);
		wr(REG_INTC0, 8'h00);
		pulse(7'h40);
		quiet(10);
		check(takes[7:0], 8'h00);
		rd_check(REG_INTC1, 8'h22);
		@(posedge clock) hold_full <= 1'b1;
		wr(REG_INTC0, 8'h01);
		quiet(10);
		check(takes[7:0], 8'h00);
		@(posedge clock) hold_full <= 1'b0;
		expect_take(VEC_CONV);
	endtask : blocked_entry

	task sleep_wake;
		wr(REG_INTC0, 8'h00);
		wr(REG_INTC1, 8'h00);
		@(posedge clock) sleeping <= 1'b1;
		pulse(7'h10);
		quiet(4);
		check({7'h00, wakes != 0}, 8'h01);
		pulse(7'h10);
		quiet(4);
		check(wakes[7:0], 8'h00);
		rd_check(REG_MFI1, 8'h40);
		@(posedge clock) sleeping <= 1'b0;
		wr(REG_MFI1, 8'h00);
		wr(REG_INTC0, 8'h00);
	endtask : sleep_wake

	task tick_case(input logic [7:0] time_base_control, input int lo, input int hi);
		wr(REG_INTC0, 8'h01);
		wr(REG_TBASE, time_base_control);
		expect_take(VEC_TICK);
		check({7'h00, n >= lo && n <= hi}, 8'h01);
		wr(REG_TBASE, 8'h30);
	endtask : tick_case

	task time_base;
		wr(REG_INTC1, 8'h04);
		for (int c = 0; c < 4; c++) begin
			tick_case(8'(8'hC0 | (c << 4)), 4 * (TB << c) - 4, 4 * (TB << c) + 8);
		end
		tick_case(8'h80, 8 * TB - 8, 8 * TB + 10);
		wr(REG_TBASE, 8'h70);
		wr(REG_INTC0, 8'h01);
		quiet(200);
		check(takes[7:0], 8'h00);
		wr(REG_INTC1, 8'h00);
	endtask : time_base

	task priority_and_return_from_interrupt;
		wr(REG_INTC1, 8'h02);
		wr(REG_MFI0, 8'h01);
		wr(REG_INTC0, 8'h02);
		pulse(7'h41);
		@(posedge clock) use_return_from_interrupt <= 1'b1;
		wr(REG_INTC0, 8'h13);
		expect_take(VEC_MF0);
		expect_take(VEC_CONV);
		@(posedge clock) use_return_from_interrupt <= 1'b0;
	endtask : priority_and_return_from_interrupt

	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		reset_values();
		conv_done_entry();
		group_entries();
		blocked_entry();
		sleep_wake();
		time_base();
		priority_and_return_from_interrupt();
		quiet(10);
		report_and_stop();
	end
endmodule : mitb_core_tb_top
